// [pkg/ebpc_defs.svh]
// constants for the external bus pin control block
`ifndef EBPC_DEFS_SVH
`define EBPC_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define EBPC_BSC_ADDR 4'h0
`define EBPC_STAT_ADDR 4'h1
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define EBPC_HOLDER_BIT 15
`define EBPC_BSC_RESET 16'h0000
`define EBPC_RESET_VECTOR 20'h0FF80
`endif

// [pkg/ebpc_pkg.sv]
// types for the external bus pin control block
package ebpc_pkg;
    typedef enum logic [1:0] {
        EBPC_SPACE_PROG,
        EBPC_SPACE_DATA,
        EBPC_SPACE_IO
    } ebpc_space_e;
    typedef enum {
        EBPC_ST_RESET,
        EBPC_ST_IDLE,
        EBPC_ST_WRITE,
        EBPC_ST_READ
    } ebpc_state_e;
endpackage

// [logic/ebpc_top.sv]
// external address and data bus pin control with data bus holders
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ebpc_defs.svh"

// Notes on behaviour
// R1: low sixteen address outputs driven for every external access of any space.
// R2: upper four address bits used only for program space; zero otherwise.
// R3: all twenty address outputs float during hold or while emulation off is low.
// R4: sixteen-bit words move over one shared two-way data bus.
// R5: data drivers off unless writing; always off in reset or on hold request.
// R6: data drivers off whenever emulation off is low, whatever the access.
// R7: with holders on and bus undriven, each line keeps its last level.
// R8: holders off at reset; software sets them by one bit in bank switching control.
// R9: reset stops the core; after release fetching starts at a fixed program address.
module ebpc_top
    import ebpc_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hold_req_i,
    input wire logic emu_off_n_i,
    input wire logic acc_req_i,
    input wire logic acc_write_i,
    input wire logic [1:0] acc_space_i,
    input wire logic [ADDR_W-1:0] acc_addr_i,
    input wire logic [DATA_W-1:0] acc_wdata_i,
    output logic acc_done_o,
    output logic [DATA_W-1:0] acc_rdata_o,
    output logic hold_ack_o,
    output logic running_o,
    output logic [ADDR_W-1:0] start_addr_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic [15:0] low_address_outputs_o,
    output logic [3:0] upper_program_address_outputs_o,
    output logic addr_oe_o,
    input wire logic [DATA_W-1:0] shared_data_lines_i,
    output logic [DATA_W-1:0] shared_data_lines_o,
    output logic shared_data_lines_oe_o,
    output logic [DATA_W-1:0] holder_drive_o,
    output logic holder_oe_o
);
    if (ADDR_W != 20 || DATA_W != 16) begin : g_width_check
        $error("ebpc_top serves a 20-bit address and 16-bit data bus only");
    end

    // ----------------------------------------
    // state and registers
    // ----------------------------------------
    ebpc_state_e state_r, state_nxt;
    logic [15:0] bsc_r, bsc_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [15:0] keep_r, keep_nxt;
    logic [15:0] reg_rdata_r, reg_rdata_nxt;
    logic done_r, done_nxt;
    logic hold_ack_r, hold_ack_nxt;
    logic bus_free;

    assign bus_free = !hold_req_i && emu_off_n_i;

    always_comb begin
        state_nxt = state_r;
        bsc_nxt = bsc_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        hold_ack_nxt = hold_req_i && (state_r != EBPC_ST_WRITE && state_r != EBPC_ST_READ);
        reg_rdata_nxt = 16'h0000;
        // software access to bank switching control and status
        if (reg_wr_i && reg_addr_i == `EBPC_BSC_ADDR) begin
            bsc_nxt = reg_wdata_i; // R8
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `EBPC_BSC_ADDR: reg_rdata_nxt = bsc_r;
                `EBPC_STAT_ADDR: reg_rdata_nxt = {13'h0000, hold_ack_r, shared_data_lines_oe_o, addr_oe_o};
                default: reg_rdata_nxt = 16'h0000;
            endcase
        end
        case (state_r)
            EBPC_ST_RESET: begin
                state_nxt = EBPC_ST_IDLE; // R9
            end
            EBPC_ST_IDLE: begin
                if (acc_req_i && !hold_req_i) begin
                    // program space keeps the top bits, others clear them
                    if (acc_space_i == EBPC_SPACE_PROG) begin
                        addr_nxt = acc_addr_i; // R2
                    end else begin
                        addr_nxt = {4'h0, acc_addr_i[15:0]}; // R1 R2
                    end
                    wdata_nxt = acc_wdata_i; // R4
                    state_nxt = acc_write_i ? EBPC_ST_WRITE : EBPC_ST_READ;
                end
            end
            EBPC_ST_WRITE: begin
                done_nxt = 1'b1;
                state_nxt = EBPC_ST_IDLE;
            end
            EBPC_ST_READ: begin
                rdata_nxt = shared_data_lines_i; // R4
                done_nxt = 1'b1;
                state_nxt = EBPC_ST_IDLE;
            end
            default: state_nxt = EBPC_ST_IDLE;
        endcase
    end

    // holder latch follows the wire while anyone drives it
    always_comb begin
        keep_nxt = shared_data_lines_oe_o ? wdata_r : shared_data_lines_i; // R7
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= EBPC_ST_RESET; // R9
            bsc_r <= `EBPC_BSC_RESET; // R8
            addr_r <= 20'h00000;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            keep_r <= 16'h0000;
            reg_rdata_r <= 16'h0000;
            done_r <= 1'b0;
            hold_ack_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bsc_r <= bsc_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            keep_r <= keep_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            done_r <= done_nxt;
            hold_ack_r <= hold_ack_nxt;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    assign low_address_outputs_o = addr_r[15:0]; // R1
    assign upper_program_address_outputs_o = addr_r[19:16]; // R2
    assign addr_oe_o = !rst_i && !hold_ack_r && emu_off_n_i; // R3
    assign shared_data_lines_o = wdata_r; // R4
    assign shared_data_lines_oe_o = !rst_i && state_r == EBPC_ST_WRITE && bus_free; // R5 R6
    assign holder_drive_o = keep_r; // R7
    assign holder_oe_o = !rst_i && bsc_r[`EBPC_HOLDER_BIT] && !shared_data_lines_oe_o; // R7 R8
    assign acc_done_o = done_r;
    assign acc_rdata_o = rdata_r;
    assign hold_ack_o = hold_ack_r;
    assign running_o = state_r != EBPC_ST_RESET;
    assign start_addr_o = `EBPC_RESET_VECTOR; // R9
    assign reg_rdata_o = reg_rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_hold_seen;
        hold_ack_r;
    endsequence

    a_addr_float_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_hold_seen |-> !addr_oe_o) // R3
        else $error("address driven during hold");
    a_addr_float_off: assert property (@(posedge ref_clk_i) disable iff (rst_i) !emu_off_n_i |-> !addr_oe_o) // R3
        else $error("address driven with emulation off low");
    a_data_off_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) hold_req_i |-> !shared_data_lines_oe_o) // R5
        else $error("data driven on hold request");
    a_data_off_emu: assert property (@(posedge ref_clk_i) disable iff (rst_i) !emu_off_n_i |-> !shared_data_lines_oe_o) // R6
        else $error("data driven with emulation off low");
    a_data_only_write: assert property (@(posedge ref_clk_i) disable iff (rst_i) shared_data_lines_oe_o |-> state_r == EBPC_ST_WRITE) // R5
        else $error("data driven outside a write");
    a_upper_zero_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_r == EBPC_ST_IDLE && acc_req_i && !hold_req_i && acc_space_i != EBPC_SPACE_PROG)
        |=> upper_program_address_outputs_o == 4'h0) // R2
        else $error("upper address used outside program space");
    a_low_addr_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_r == EBPC_ST_IDLE && acc_req_i && !hold_req_i) |=> low_address_outputs_o == $past(acc_addr_i[15:0])) // R1
        else $error("low address not taken");
    a_holder_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_addr_i == `EBPC_BSC_ADDR && !reg_wdata_i[`EBPC_HOLDER_BIT]) |=> !holder_oe_o) // R8
        else $error("holder on after disable write");
    a_holder_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!shared_data_lines_oe_o ##1 holder_oe_o) |-> holder_drive_o == $past(shared_data_lines_i)) // R7
        else $error("holder lost last level");
    a_reset_leave: assert property (@(posedge ref_clk_i) disable iff (rst_i) state_r == EBPC_ST_RESET |=> running_o) // R9
        else $error("core did not leave reset");

    sequence s_access_taken;
        state_r == EBPC_ST_IDLE && acc_req_i && !hold_req_i;
    endsequence

    a_access_done: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_access_taken |-> ##2 acc_done_o) // R4
        else $error("access not finished in two cycles");
    a_read_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_access_taken ##0 !acc_write_i) |-> ##2 acc_rdata_o == $past(shared_data_lines_i)) // R4
        else $error("read data not taken from the bus");
    a_write_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_access_taken ##0 acc_write_i) |=> shared_data_lines_o == $past(acc_wdata_i)) // R4
        else $error("write data not presented");
    a_upper_prog: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_access_taken ##0 acc_space_i == EBPC_SPACE_PROG) |=> upper_program_address_outputs_o == $past(acc_addr_i[19:16])) // R2
        else $error("upper program address not taken");
    a_data_off_rst: assert property (@(posedge ref_clk_i) rst_i |-> !shared_data_lines_oe_o && !holder_oe_o && !addr_oe_o) // R5
        else $error("pin driven during reset");
    a_hold_ack_req: assert property (@(posedge ref_clk_i) disable iff (rst_i) hold_ack_o |-> $past(hold_req_i)) // R3
        else $error("hold granted without request");
    a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i) acc_done_o |=> !acc_done_o) // R4
        else $error("done longer than one cycle");
    a_addr_oe_free: assert property (@(posedge ref_clk_i) disable iff (rst_i) !hold_ack_r && emu_off_n_i |-> addr_oe_o) // R1
        else $error("address not driven while bus free");
    a_holder_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        bsc_r[`EBPC_HOLDER_BIT] && !shared_data_lines_oe_o |-> holder_oe_o) // R7
        else $error("holder off while enabled and bus undriven");
    a_data_drive_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_r == EBPC_ST_WRITE && !hold_req_i && emu_off_n_i |-> shared_data_lines_oe_o) // R5
        else $error("write data not driven on a free bus");
    a_reg_idle_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) !reg_rd_i |=> reg_rdata_o == 16'h0000) // R8
        else $error("read data outside the read answer cycle");
endmodule

// [testbench/ebpc_mem_model.sv]
// external memory model on the shared data lines
`timescale 1ns/1ps
module ebpc_mem_model (
    input wire logic ref_clk_i,
    input wire logic en_i,
    input wire logic addr_oe_i,
    input wire logic [15:0] addr_i,
    input wire logic dut_oe_i,
    input wire logic [15:0] bus_i,
    output logic [15:0] data_o,
    output logic oe_o
);
    logic [15:0] mem [16];
    assign oe_o = en_i && addr_oe_i && !dut_oe_i;
    assign data_o = oe_o ? mem[addr_i[3:0]] : ~bus_i;
    always @(posedge ref_clk_i) begin
        if (dut_oe_i) mem[addr_i[3:0]] <= bus_i;
    end
endmodule

// [testbench/test_ebpc_top.sv]
// self-checking bench for the external bus pin control block
`timescale 1ns/1ps
`include "ebpc_defs.svh"
module test_ebpc_top;
    logic ref_clk_i = 0, rst_i = 1, hold_req_i = 0, emu_off_n_i = 1, acc_req_i = 0, acc_write_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0, acc_done_o, hold_ack_o, running_o, addr_oe_o, shared_data_lines_oe_o;
    logic holder_oe_o, mem_en = 0, mem_oe, rd_d = 0;
    logic [1:0] acc_space_i = 0;
    logic [3:0] reg_addr_i = 0, upper_program_address_outputs_o;
    logic [15:0] acc_wdata_i = 0, reg_wdata_i = 0, acc_rdata_o, reg_rdata_o, low_address_outputs_o;
    logic [15:0] shared_data_lines_o, holder_drive_o, mem_d, bus, last = 0;
    logic [19:0] acc_addr_i = 0, start_addr_o;
    logic [16:0] acc_q[$];
    logic [15:0] reg_q[$];
    int fail_count = 0, checked = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    assign bus = shared_data_lines_oe_o ? shared_data_lines_o : mem_oe ? mem_d : holder_oe_o ? holder_drive_o : ~last;
    always @(posedge ref_clk_i) last <= bus;
    ebpc_top i_dut (.ref_clk_i, .rst_i, .hold_req_i, .emu_off_n_i, .acc_req_i, .acc_write_i, .acc_space_i,
        .acc_addr_i, .acc_wdata_i, .acc_done_o, .acc_rdata_o, .hold_ack_o, .running_o, .start_addr_o,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .low_address_outputs_o,
        .upper_program_address_outputs_o, .addr_oe_o, .shared_data_lines_i(bus), .shared_data_lines_o,
        .shared_data_lines_oe_o, .holder_drive_o, .holder_oe_o);
    ebpc_mem_model i_mem (.ref_clk_i, .en_i(mem_en), .addr_oe_i(addr_oe_o), .addr_i(low_address_outputs_o),
        .dut_oe_i(shared_data_lines_oe_o), .bus_i(bus), .data_o(mem_d), .oe_o(mem_oe));
    task automatic complete_run();
        $display("mismatches %0d checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [19:0] e, logic [19:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic reg_op(logic w, logic [3:0] a, logic [15:0] d);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!w) reg_q.push_back(d);
        @(posedge ref_clk_i);
        reg_wr_i <= 0;
        reg_rd_i <= 0;
        @(posedge ref_clk_i);
    endtask
    task automatic acc(logic w, logic [1:0] sp, logic [19:0] a, logic [15:0] d, logic eo);
        int n;
        acc_req_i <= 1;
        acc_write_i <= w;
        acc_space_i <= sp;
        acc_addr_i <= a;
        acc_wdata_i <= d;
        acc_q.push_back({!w, d});
        @(posedge ref_clk_i);
        acc_req_i <= 0;
        #1;
        chk("low_addr", 20'(a[15:0]), 20'(low_address_outputs_o));
        chk("up_addr", 20'(sp == 0 ? a[19:16] : 4'h0), 20'(upper_program_address_outputs_o));
        chk("addr_oe", 20'(eo), 20'(addr_oe_o));
        chk("data_oe", 20'(w & eo), 20'(shared_data_lines_oe_o));
        if (w & eo) chk("bus", 20'(d), 20'(bus));
        for (n = 0; n < 9 && acc_done_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
        if (n == 9) begin
            fail_count++;
            complete_run();
        end else begin
            @(posedge ref_clk_i);
        end
    endtask
    always @(posedge ref_clk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) chk("reg_rdata", 20'(reg_q.pop_front()), 20'(reg_rdata_o));
        if (acc_done_o && acc_q.size() > 0 && acc_q[0][16]) chk("rdata", 20'(acc_q[0][15:0]), 20'(acc_rdata_o));
        if (acc_done_o && acc_q.size() > 0) void'(acc_q.pop_front());
    end
    initial begin
        logic [19:0] a;
        logic [15:0] d;
        void'($urandom(32'hEA1D7187));
        repeat (8) @(posedge ref_clk_i);
        chk("rst_oe", 20'h0, 20'({addr_oe_o, shared_data_lines_oe_o, holder_oe_o}));
        rst_i <= 0;
        repeat (2) @(posedge ref_clk_i);
        chk("running", 20'h1, 20'(running_o));
        chk("start", `EBPC_RESET_VECTOR, start_addr_o);
        reg_op(0, `EBPC_BSC_ADDR, `EBPC_BSC_RESET);
        reg_op(0, 4'hF, 16'h0000);
        reg_op(1, `EBPC_BSC_ADDR, 16'h8000);
        reg_op(0, `EBPC_BSC_ADDR, 16'h8000);
        mem_en <= 1;
        for (int s = 0; s < 3; s++) begin
            a = 20'($urandom());
            d = 16'($urandom());
            acc(1, 2'(s), a, d, 1);
            acc(0, 2'(s), a, d, 1);
        end
        mem_en <= 0;
        acc(1, 1, a, 16'h5AC3, 1);
        repeat (3) @(posedge ref_clk_i);
        chk("holder_oe", 20'h1, 20'(holder_oe_o));
        chk("holder", 20'h5AC3, 20'(holder_drive_o));
        reg_op(1, `EBPC_BSC_ADDR, 16'h0000);
        chk("holder_off", 20'h0, 20'(holder_oe_o));
        hold_req_i <= 1;
        repeat (4) @(posedge ref_clk_i);
        chk("hold", 20'h4, 20'({hold_ack_o, addr_oe_o, shared_data_lines_oe_o}));
        reg_op(0, `EBPC_STAT_ADDR, 16'h0004);
        hold_req_i <= 0;
        emu_off_n_i <= 0;
        @(posedge ref_clk_i);
        acc(1, 0, a, d, 0);
        reg_op(1, `EBPC_BSC_ADDR, 16'h8000);
        emu_off_n_i <= 1;
        rst_i <= 1;
        @(posedge ref_clk_i);
        rst_i <= 0;
        @(posedge ref_clk_i);
        chk("holder_rst", 20'h0, 20'(holder_oe_o));
        reg_op(0, `EBPC_BSC_ADDR, 16'h0000);
        reg_op(0, `EBPC_STAT_ADDR, 16'h0001);
        repeat (2) @(posedge ref_clk_i);
        chk("queues", 20'h0, 20'(reg_q.size() + acc_q.size()));
        complete_run();
    end
endmodule
